// [cwc_pkg.sv]
// Constants, types and helpers of the config word checksum block.
// Assumes one clock and a plain strobe register port.
package cwc_pkg;
    localparam int CWC_AW = 8;
    localparam int CWC_DW = 16;
    localparam int CWC_PW = 14;
    localparam int CWC_MW = 13;
    localparam logic [7:0] CWC_OFS_CTRL = 8'h00;
    localparam logic [7:0] CWC_OFS_STAT = 8'h04;
    localparam logic [7:0] CWC_OFS_CFG = 8'h08;
    localparam logic [7:0] CWC_OFS_SUM = 8'h0C;
    localparam logic [7:0] CWC_OFS_ID0 = 8'h10;
    localparam logic [7:0] CWC_OFS_MADDR = 8'h20;
    localparam logic [7:0] CWC_OFS_MDATA = 8'h24;
    localparam int CWC_CTRL_START = 0;
    localparam int CWC_CTRL_SIZE = 1;
    localparam int CWC_CP_HI = 12;
    localparam int CWC_CP_LO = 4;
    localparam logic [13:0] CWC_CFG_MASK = 14'h3BFF;
    localparam logic [13:0] CWC_CFG_FORCE = 14'h0400;
    localparam logic [13:0] CWC_CFG_RST = 14'h3FFF;
    localparam logic [13:0] CWC_ID_RST = 14'h3FFF;
    localparam logic [15:0] CWC_SUM_RST = 16'h0000;
    localparam logic [12:0] CWC_PTR_RST = 13'h0000;
    localparam logic [1:0] CWC_SIZE_RST = 2'h2;
    localparam logic [1:0] CWC_SZ_2K = 2'h0;
    localparam logic [1:0] CWC_SZ_4K = 2'h1;
    localparam logic [13:0] CWC_WORDS_2K = 14'h0800;
    localparam logic [13:0] CWC_WORDS_4K = 14'h1000;
    localparam logic [13:0] CWC_WORDS_8K = 14'h2000;
    localparam logic [13:0] CWC_TOP_WORDS = 14'h0100;
    typedef enum logic [5:0] {
        CWC_IDLE = 6'h01, CWC_SCAN = 6'h02, CWC_DRAIN = 6'h04,
        CWC_CFG = 6'h08, CWC_ID = 6'h10, CWC_FIN = 6'h20
    } cwc_state_e;
    typedef enum logic [1:0] {
        CWC_PROT_ALL = 2'h0, CWC_PROT_HALF = 2'h1,
        CWC_PROT_TOP = 2'h2, CWC_PROT_NONE = 2'h3
    } cwc_prot_e;
    typedef enum logic [1:0] {
        CWC_OSC_LOW = 2'h0, CWC_OSC_XT = 2'h1,
        CWC_OSC_HS = 2'h2, CWC_OSC_RC = 2'h3
    } cwc_osc_e;
    typedef struct packed {
        cwc_prot_e prot;
        cwc_osc_e osc;
        logic unsup;
    } cwc_view_s;
    function automatic logic [13:0] cwc_words(input logic [1:0] sz);
        case (sz)
            CWC_SZ_2K: cwc_words = CWC_WORDS_2K;
            CWC_SZ_4K: cwc_words = CWC_WORDS_4K;
            default: cwc_words = CWC_WORDS_8K;
        endcase
    endfunction
    // Partial protection codes only exist on the larger parts
    function automatic cwc_prot_e cwc_prot(input logic [1:0] sz,
                                           input logic [1:0] cp);
        if (cp == 2'h0 || cp == 2'h3 || sz != CWC_SZ_2K) begin
            cwc_prot = cwc_prot_e'(cp);
        end else begin
            cwc_prot = CWC_PROT_NONE;
        end
    endfunction
    // First protected address; the summed range ends just below it
    function automatic logic [13:0] cwc_limit(input logic [1:0] sz,
                                              input cwc_prot_e p);
        logic [13:0] w;
        w = cwc_words(sz);
        case (p)
            CWC_PROT_TOP: cwc_limit = w - CWC_TOP_WORDS;
            CWC_PROT_HALF: cwc_limit = {1'b0, w[13:1]};
            CWC_PROT_ALL: cwc_limit = 14'h0000;
            default: cwc_limit = w;
        endcase
    endfunction
endpackage

// [cwc_mem.sv]
// Program memory array with one write and one registered read port.
// Assumes writer and reader share the single clock.
`timescale 1ns/100ps
module cwc_mem #(
    parameter int AW = 13,
    parameter int DW = 14
) (
    // Clock
    input wire logic i_ref_clk,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read port
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    import cwc_pkg::*;
    // No reset: contents are unknown until software loads them
    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_q[i_raddr];
    end
endmodule // cwc_mem

// [cwc_accum.sv]
// Wrapping running-sum accumulator of the checksum engine.
// Assumes operands come from logic on the same clock.
`timescale 1ns/100ps
module cwc_accum #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Operand stream
    input wire logic i_clear,
    input wire logic i_valid,
    input wire logic [W-1:0] i_operand,
    // Result
    output logic [W-1:0] o_sum
);
    import cwc_pkg::*;
    logic [W-1:0] sum_d;
    // Carry out of the top bit simply falls off
    assign sum_d = i_clear ? '0 : i_valid ? sum_q_add(o_sum, i_operand)
                                          : o_sum;
    function automatic logic [W-1:0] sum_q_add(input logic [W-1:0] a,
                                               input logic [W-1:0] b);
        sum_q_add = a + b;
    endfunction
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sum <= '0;
        end else begin
            o_sum <= sum_d;
        end
    end
    property p_clear;
        @(posedge i_ref_clk) disable iff (i_rst)
            i_clear |=> o_sum == '0;
    endproperty
    acc_clear_a: assert property (p_clear)
        else $error("sum not cleared after clear");
    property p_wrap;
        @(posedge i_ref_clk) disable iff (i_rst)
            i_valid && !i_clear |=>
                o_sum == sum_q_add($past(o_sum), $past(i_operand));
    endproperty
    acc_wrap_a: assert property (p_wrap)
        else $error("sum did not add operand modulo width");
endmodule // cwc_accum

// [cwc_checksum.sv]
// Checksum engine and configuration word decode of a small flash part.
// Assumes a strobe register port on the same clock; the host loads
// program memory, configuration and ID words before starting a run.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module cwc_checksum (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [cwc_pkg::CWC_AW-1:0] i_addr,
    input wire logic [cwc_pkg::CWC_DW-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cwc_pkg::CWC_DW-1:0] o_rd_data,
    // Engine results
    output logic [cwc_pkg::CWC_DW-1:0] o_checksum,
    output logic o_busy,
    output logic o_done,
    // Decoded configuration
    output cwc_pkg::cwc_view_s o_cfg_view
);
    import cwc_pkg::*;

    cwc_state_e state_q;
    cwc_state_e state_d;
    logic [CWC_PW-1:0] cfg_q;
    logic [CWC_PW-1:0] id_q [0:3];
    logic [1:0] size_q;
    logic [CWC_MW-1:0] ptr_q;
    logic [CWC_MW-1:0] ptr_d;
    logic [CWC_MW-1:0] scan_q;
    logic [CWC_DW-1:0] sum_q;
    logic [CWC_DW-1:0] rd_data_q;
    logic [CWC_DW-1:0] rd_data_d;
    logic done_q;
    logic done_d;
    logic busy_q;
    logic mem_vld_q;
    logic prot_rd_q;
    logic prot_rd_d;
    cwc_view_s view_q;
    cwc_view_s view_d;

    logic idle;
    logic hit_id;
    logic [1:0] id_sel;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_id;
    logic wr_maddr;
    logic wr_mdata;
    logic start_ok;
    logic [1:0] cp_eff;
    cwc_prot_e prot_now;
    logic [13:0] lim;
    logic [13:0] last_addr;
    logic scan_last;
    logic [CWC_MW-1:0] mem_raddr;
    logic [CWC_PW-1:0] mem_rdata;
    logic [CWC_PW-1:0] cfg_masked;
    logic [CWC_DW-1:0] id_packed;
    logic [CWC_DW-1:0] acc_op;
    logic [CWC_DW-1:0] acc_sum;
    logic acc_vld;
    logic in_cfg;
    logic in_id;

    // Register decode; all setup writes are refused while a run is on,
    // so the summed range and operands cannot move under the engine
    assign idle = state_q == CWC_IDLE;
    assign hit_id = i_addr[7:4] == CWC_OFS_ID0[7:4] && i_addr[1:0] == 2'h0;
    assign id_sel = i_addr[3:2];
    assign wr_ctrl = i_wr && idle && i_addr == CWC_OFS_CTRL;
    assign wr_cfg = i_wr && idle && i_addr == CWC_OFS_CFG;
    assign wr_id = i_wr && idle && hit_id;
    assign wr_maddr = i_wr && idle && i_addr == CWC_OFS_MADDR;
    assign wr_mdata = i_wr && idle && i_addr == CWC_OFS_MDATA;
    assign start_ok = wr_ctrl && i_wr_data[CWC_CTRL_START];

    // Either copy of the protect field being programmed protects
    assign cp_eff = cfg_q[CWC_CP_HI +: 2] & cfg_q[CWC_CP_LO +: 2];
    assign prot_now = cwc_prot(size_q, cp_eff);
    assign view_d.prot = prot_now;
    assign view_d.osc = cwc_osc_e'(cfg_q[1:0]);
    assign view_d.unsup = size_q == CWC_SZ_2K && cp_eff != 2'h0
                          && cp_eff != 2'h3;

    // Summed range: 0 up to one below the first protected word
    assign lim = cwc_limit(size_q, prot_now);
    assign last_addr = lim - 14'h0001;
    assign scan_last = {1'b0, scan_q} == last_addr;

    // Program memory pointer auto-increments after each data write
    assign ptr_d = wr_maddr ? i_wr_data[CWC_MW-1:0]
                 : wr_mdata ? ptr_q + 13'h0001
                 : ptr_q;
    // Look ahead to the next pointer so a read may follow at once
    assign mem_raddr = idle ? ptr_d : scan_q;
    // Readback hides protected words and anything read mid-run
    assign prot_rd_d = !idle || {1'b0, ptr_d} >= lim;

    // Operand selection for the accumulator
    assign in_cfg = state_q == CWC_CFG;
    assign in_id = state_q == CWC_ID;
    assign cfg_masked = cfg_q & CWC_CFG_MASK;
    assign id_packed = {id_q[0][3:0], id_q[1][3:0],
                        id_q[2][3:0], id_q[3][3:0]};
    assign acc_vld = mem_vld_q || in_cfg || in_id;
    assign acc_op = mem_vld_q ? {2'h0, mem_rdata}
                  : in_cfg ? {2'h0, cfg_masked}
                  : id_packed;

    // Read data; config and ID answer whatever the protection
    assign rd_data_d = !i_rd ? CWC_SUM_RST
        : i_addr == CWC_OFS_CTRL ? {13'h0000, size_q, 1'b0}
        : i_addr == CWC_OFS_STAT ? {13'h0000, view_q.unsup, done_q, busy_q}
        : i_addr == CWC_OFS_CFG ? {2'h0, cfg_q | CWC_CFG_FORCE}
        : i_addr == CWC_OFS_SUM ? sum_q
        : hit_id ? {2'h0, id_q[id_sel]}
        : i_addr == CWC_OFS_MADDR ? {3'h0, ptr_q}
        : i_addr == CWC_OFS_MDATA ?
              (prot_rd_q ? CWC_SUM_RST : {2'h0, mem_rdata})
        : CWC_SUM_RST;

    // A new run clears done; finishing sets it, and setting wins
    assign done_d = (state_q == CWC_FIN) || (done_q && !start_ok);

    // Engine sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            CWC_IDLE: begin
                if (start_ok) begin
                    // Nothing to scan when all memory is protected
                    state_d = (lim == 14'h0000) ? CWC_CFG : CWC_SCAN;
                end
            end
            CWC_SCAN: begin
                if (scan_last) begin
                    state_d = CWC_DRAIN;
                end
            end
            CWC_DRAIN: begin
                state_d = CWC_CFG;
            end
            CWC_CFG: begin
                // ID value joins the sum only under some protection
                state_d = (prot_now == CWC_PROT_NONE) ? CWC_FIN
                                                      : CWC_ID;
            end
            CWC_ID: begin
                state_d = CWC_FIN;
            end
            CWC_FIN: begin
                state_d = CWC_IDLE;
            end
            default: begin
                state_d = CWC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= CWC_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            mem_vld_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= state_d != CWC_IDLE;
            done_q <= done_d;
            mem_vld_q <= state_q == CWC_SCAN;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || start_ok) begin
            scan_q <= CWC_PTR_RST;
        end else if (state_q == CWC_SCAN) begin
            scan_q <= scan_q + 13'h0001;
        end
    end

    // Erased configuration bits read as ones
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cfg_q <= CWC_CFG_RST;
            size_q <= CWC_SIZE_RST;
        end else begin
            if (wr_cfg) begin
                cfg_q <= i_wr_data[CWC_PW-1:0];
            end
            if (wr_ctrl) begin
                size_q <= i_wr_data[CWC_CTRL_SIZE +: 2];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 4; k++) begin
                id_q[k] <= CWC_ID_RST;
            end
        end else if (wr_id) begin
            id_q[id_sel] <= i_wr_data[CWC_PW-1:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ptr_q <= CWC_PTR_RST;
            prot_rd_q <= 1'b1;
            rd_data_q <= CWC_SUM_RST;
            sum_q <= CWC_SUM_RST;
            view_q <= '{CWC_PROT_NONE, CWC_OSC_RC, 1'b0};
        end else begin
            ptr_q <= ptr_d;
            prot_rd_q <= prot_rd_d;
            rd_data_q <= rd_data_d;
            view_q <= view_d;
            if (state_q == CWC_FIN) begin
                sum_q <= acc_sum;
            end
        end
    end

    cwc_mem #(
        .AW(CWC_MW),
        .DW(CWC_PW)
    ) u_mem (
        .i_ref_clk(i_ref_clk),
        .i_we(wr_mdata),
        .i_waddr(ptr_q),
        .i_wdata(i_wr_data[CWC_PW-1:0]),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );

    cwc_accum #(
        .W(CWC_DW)
    ) u_accum (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clear(start_ok),
        .i_valid(acc_vld),
        .i_operand(acc_op),
        .o_sum(acc_sum)
    );

    assign o_rd_data = rd_data_q;
    assign o_checksum = sum_q;
    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_cfg_view = view_q;

    // Checks
    sequence s_scan_last;
        state_q == CWC_SCAN && scan_last;
    endsequence
    sequence s_cfg_add;
        in_cfg && acc_vld && acc_op == {2'h0, cfg_q & CWC_CFG_MASK};
    endsequence

    property p_scan_end;
        @(posedge i_ref_clk) disable iff (i_rst)
            s_scan_last |=> state_q == CWC_DRAIN && mem_vld_q
                ##1 s_cfg_add;
    endproperty
    scan_end_a: assert property (p_scan_end)
        else $error("scan did not end into config add");

    property p_range;
        @(posedge i_ref_clk) disable iff (i_rst)
            state_q == CWC_SCAN |-> {1'b0, scan_q} < lim;
    endproperty
    scan_range_a: assert property (p_range)
        else $error("scan passed the protected boundary");

    property p_all_prot;
        @(posedge i_ref_clk) disable iff (i_rst)
            start_ok && prot_now == CWC_PROT_ALL |=>
                (s_cfg_add and !mem_vld_q) ##1 in_id && !mem_vld_q;
    endproperty
    all_prot_a: assert property (p_all_prot)
        else $error("memory summed under full protection");

    property p_no_id;
        @(posedge i_ref_clk) disable iff (i_rst)
            s_cfg_add ##0 prot_now == CWC_PROT_NONE |=>
                state_q == CWC_FIN && !acc_vld;
    endproperty
    no_id_a: assert property (p_no_id)
        else $error("ID value added with protection off");

    property p_id_pack;
        @(posedge i_ref_clk) disable iff (i_rst)
            in_id |-> acc_vld && acc_op[15:12] == id_q[0][3:0]
                && acc_op[3:0] == id_q[3][3:0];
    endproperty
    id_pack_a: assert property (p_id_pack)
        else $error("ID nibbles packed in wrong order");

    property p_fin;
        @(posedge i_ref_clk) disable iff (i_rst)
            state_q == CWC_FIN |=>
                o_checksum == $past(acc_sum) && o_done && !o_busy;
    endproperty
    fin_sum_a: assert property (p_fin)
        else $error("checksum not published at end of run");

    property p_prot_read;
        @(posedge i_ref_clk) disable iff (i_rst)
            i_rd && i_addr == CWC_OFS_MDATA && prot_rd_q |=>
                o_rd_data == CWC_SUM_RST;
    endproperty
    prot_read_a: assert property (p_prot_read)
        else $error("protected word read back unaltered");

    property p_cfg_read;
        @(posedge i_ref_clk) disable iff (i_rst)
            i_rd && i_addr == CWC_OFS_CFG |=>
                o_rd_data == {2'h0, $past(cfg_q) | CWC_CFG_FORCE};
    endproperty
    cfg_read_a: assert property (p_cfg_read)
        else $error("config word read back wrong");

    property p_osc;
        @(posedge i_ref_clk) disable iff (i_rst)
            !$stable(cfg_q) |=> o_cfg_view.osc == $past(cfg_q[1:0]);
    endproperty
    osc_decode_a: assert property (p_osc)
        else $error("oscillator field decoded wrong");

    property p_cp;
        @(posedge i_ref_clk) disable iff (i_rst)
            cp_eff == 2'h0 |=> o_cfg_view.prot == CWC_PROT_ALL;
    endproperty
    cp_decode_a: assert property (p_cp)
        else $error("full protection not decoded");
endmodule // cwc_checksum

// [cwc_prog_model.sv]
// Programmer model: drives the register port and sums memory as read.
// Assumes the device answers a read in the cycle after the strobe.
`timescale 1ns/100ps
module cwc_prog_model (
    // Clock
    input wire logic i_ref_clk,
    // Register port toward the device
    output logic [cwc_pkg::CWC_AW-1:0] o_addr,
    output logic [cwc_pkg::CWC_DW-1:0] o_wr_data,
    output logic o_wr,
    output logic o_rd,
    input wire logic [cwc_pkg::CWC_DW-1:0] i_rd_data
);
    import cwc_pkg::*;
    initial begin
        o_addr = 8'h00;
        o_wr_data = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Each access holds the port for exactly one rising edge
    task automatic acc(input logic w, input logic r,
                       input logic [CWC_AW-1:0] a,
                       input logic [CWC_DW-1:0] d);
        o_wr <= w;
        o_rd <= r;
        o_addr <= a;
        o_wr_data <= d;
        @(posedge i_ref_clk);
    endtask
    task automatic wr(input logic [CWC_AW-1:0] a,
                      input logic [CWC_DW-1:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask
    // Idle lines toggle so a stale address never looks valid
    task automatic idle();
        acc(1'b0, 1'b0, ~o_addr, ~o_wr_data);
    endtask
    task automatic rd(input logic [CWC_AW-1:0] a,
                      output logic [CWC_DW-1:0] q);
        acc(1'b0, 1'b1, a, ~o_wr_data);
        // Strobe drops for one edge; the answer is sampled at that edge
        idle();
        q = i_rd_data;
    endtask
    task automatic prog_sum(output logic [CWC_DW-1:0] s);
        logic [CWC_DW-1:0] q;
        logic [CWC_DW-1:0] cfg;
        logic [CWC_DW-1:0] pid;
        s = 16'h0000;
        pid = 16'h0000;
        for (int i = 0; i < 8192; i++) begin
            wr(CWC_OFS_MADDR, 16'(i));
            rd(CWC_OFS_MDATA, q);
            s = s + q;
        end
        for (int k = 0; k < 4; k++) begin
            rd(CWC_OFS_ID0 + 8'(4 * k), q);
            pid = {pid[11:0], q[3:0]};
        end
        rd(CWC_OFS_CFG, cfg);
        s = s + (cfg & {2'b00, CWC_CFG_MASK});
        if ((cfg[13:12] & cfg[5:4]) != 2'h3) begin
            s = s + pid;
        end
        idle();
    endtask
endmodule // cwc_prog_model

// [cwc_checksum_tb.sv]
// Self-checking bench of the checksum engine, all sizes and protections.
// Assumes the programmer model owns the register port throughout.
`timescale 1ns/100ps
module cwc_checksum_tb;
    import cwc_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [CWC_AW-1:0] i_addr;
    logic [CWC_DW-1:0] i_wr_data;
    logic i_wr;
    logic i_rd;
    logic [CWC_DW-1:0] o_rd_data;
    logic [CWC_DW-1:0] o_checksum;
    logic o_busy;
    logic o_done;
    cwc_view_s o_cfg_view;
    int n_fail = 0;
    int check_count = 0;
    logic [15:0] last_exp = 16'h0000;
    always #5 i_ref_clk = ~i_ref_clk;
    cwc_checksum cwc_checksum_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
        .o_rd_data(o_rd_data), .o_checksum(o_checksum), .o_busy(o_busy),
        .o_done(o_done), .o_cfg_view(o_cfg_view));
    cwc_prog_model cwc_prog_model_inst (.i_ref_clk(i_ref_clk),
        .o_addr(i_addr), .o_wr_data(i_wr_data), .o_wr(i_wr), .o_rd(i_rd),
        .i_rd_data(o_rd_data));
    task automatic wrap_up();
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [13:0] pat(input int i);
        pat = 14'(i * 13) + 14'h25E6;
    endfunction
    task automatic reset_values();
        logic [15:0] q;
        cwc_prog_model_inst.rd(CWC_OFS_CFG, q);
        chk("cfg reset", q, 16'h3FFF);
        cwc_prog_model_inst.rd(CWC_OFS_ID0, q);
        chk("id reset", q, 16'h3FFF);
        cwc_prog_model_inst.rd(CWC_OFS_CTRL, q);
        chk("ctrl reset", q, 16'h0004);
        cwc_prog_model_inst.rd(CWC_OFS_SUM, q);
        chk("sum reset", q, 16'h0000);
        cwc_prog_model_inst.rd(8'h3C, q);
        chk("unmapped", q, 16'h0000);
        chk("view reset", {11'h000, o_cfg_view}, 16'h001E);
    endtask
    task automatic load_all();
        logic [15:0] q;
        cwc_prog_model_inst.wr(CWC_OFS_MADDR, 16'h0000);
        for (int i = 0; i < 8192; i++) begin
            cwc_prog_model_inst.wr(CWC_OFS_MDATA, {2'b00, pat(i)});
        end
        for (int k = 0; k < 4; k++) begin
            cwc_prog_model_inst.wr(CWC_OFS_ID0 + 8'(4 * k),
                                   {12'h3AB, 4'(k + 1)});
        end
        cwc_prog_model_inst.wr(CWC_OFS_MADDR, 16'h0005);
        cwc_prog_model_inst.rd(CWC_OFS_MDATA, q);
        chk("mem word", q, {2'b00, pat(5)});
    endtask
    task automatic run_case(input logic [1:0] sz, input logic [1:0] cp,
                            input logic [1:0] osc);
        logic [13:0] cfg;
        logic [15:0] s;
        logic [15:0] q;
        int w;
        int lim;
        int lat;
        int t;
        bit un;
        w = 2048 << sz;
        un = (sz == 2'h0) && (cp == 2'h1 || cp == 2'h2);
        case (cp)
            2'h3: lim = w;
            2'h2: lim = un ? w : w - 256;
            2'h1: lim = un ? w : w / 2;
            default: lim = 0;
        endcase
        lat = (lim == 0) ? 4 : (lim < w ? lim + 5 : lim + 4);
        cfg = {cp, 6'h3F, cp, 2'h3, osc};
        s = {2'b00, cfg & CWC_CFG_MASK};
        for (int i = 0; i < lim; i++) begin
            s = s + {2'b00, pat(i)};
        end
        if (lim < w) begin
            s = s + 16'h1234;
        end
        cwc_prog_model_inst.wr(CWC_OFS_CFG, {2'b00, cfg});
        cwc_prog_model_inst.wr(CWC_OFS_CTRL, {13'h0000, sz, 1'b1});
        // Lands while busy, so it must leave the configuration alone
        cwc_prog_model_inst.wr(CWC_OFS_CFG, 16'h0000);
        cwc_prog_model_inst.idle();
        @(negedge i_ref_clk);
        t = 3;
        chk("busy", {15'h0000, o_busy}, 16'h0001);
        while (o_done !== 1'b1 && t < 9000) begin
            @(negedge i_ref_clk);
            t++;
        end
        @(posedge i_ref_clk);
        chk("latency", 16'(t), 16'(lat));
        chk("checksum", o_checksum, s);
        last_exp = s;
        chk("view", {11'h000, o_cfg_view},
            {11'h000, un ? 2'h3 : cp, osc, un});
        cwc_prog_model_inst.rd(CWC_OFS_STAT, q);
        chk("status", q, {13'h0000, un, 2'b10});
        cwc_prog_model_inst.rd(CWC_OFS_CFG, q);
        chk("cfg kept", q, {2'b00, cfg | 14'h0400});
    endtask
    task automatic programmer_view();
        logic [15:0] s;
        cwc_prog_model_inst.prog_sum(s);
        chk("readback sum", s, o_checksum);
        chk("readback golden", s, last_exp);
    endtask
    // About 69k cycles of work; the limit allows a margin
    initial begin
        #1000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        reset_values();
        load_all();
        run_case(2'h0, 2'h3, 2'h3);
        run_case(2'h0, 2'h2, 2'h2);
        run_case(2'h0, 2'h1, 2'h1);
        run_case(2'h0, 2'h0, 2'h0);
        run_case(2'h1, 2'h2, 2'h3);
        run_case(2'h1, 2'h1, 2'h2);
        run_case(2'h1, 2'h3, 2'h1);
        run_case(2'h2, 2'h3, 2'h1);
        run_case(2'h2, 2'h1, 2'h2);
        run_case(2'h2, 2'h0, 2'h3);
        run_case(2'h2, 2'h2, 2'h0);
        programmer_view();
        wrap_up();
    end
endmodule // cwc_checksum_tb
